// ===== verilog/eep_pkg.sv
// Contract
// - Data falling with clock high is a start; rising with clock high a stop.
// - Stop ends a read; after a write it launches programming, then standby.
// - Data changes only with clock low; changes with clock high are start or stop.
// - Bytes are eight bits; the receiver pulls data low in the ninth clock.
// - During writes the device only receives and acknowledges every byte low.
// - Read acknowledges the address, sends data, and continues while master acknowledges.
// - Without master acknowledge the device releases data and waits for a stop.
// - Address byte upper nibble must be 1010; the three select bits are ignored.
// - Address byte bit zero set means read, clear means write.
// - A wrong device code makes the device ignore the whole instruction.
// - Address, word address, one data byte and stop program that one byte.
// - While programming, no instruction is taken and no address byte acknowledged.
// - Page writes keep address bits three to seven and wrap bits zero to two.
// - More than eight page bytes leave only the last eight for programming.
// - Polling address bytes get no acknowledge while busy, low acknowledge once done.
// - Protect high blocks the whole small array, or the upper half of the large.
// - Protect rising mid programming does not abort it; reads ignore protect.
// - Address counter points past last access, advances after eighth bit, wraps.
// - Random read is a dummy write of the word address, then repeated start read.
package eep_pkg;
    localparam logic [3:0] DEV_CODE = 4'ha;
    localparam logic [3:0] BYTE_END = 4'h8;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WRITE_TIME_MS = 10;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [31:0] TMR_ONE = 32'h0000_0001;
    localparam int MEM_BYTES_DEF = 256;
    localparam int SMALL_BYTES = 128;
    localparam int PAGE_BYTES = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_DACK = 4'h2,
        ST_WADR = 4'h3,
        ST_AACK = 4'h4,
        ST_WDAT = 4'h5,
        ST_WACK = 4'h6,
        ST_RDAT = 4'h7,
        ST_RACK = 4'h8,
        ST_IGN = 4'h9
    } eep_st_type;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic wp_m;
        logic wp_s;
        eep_st_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] addr;
        logic [4:0] page;
        logic [7:0][7:0] pbuf;
        logic [7:0] mask;
        logic mack;
        logic busy;
        logic blk;
        logic [31:0] tmr;
        logic sda_oe;
        logic sda_out;
    } eep_state_type;

    localparam eep_state_type RST_STATE = '0;
endpackage

// ===== verilog/eep_slave.sv
`timescale 1ns/100ps
module eep_slave
    import eep_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_DEF,
    parameter int PROG_CYCLES = WRITE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic wp_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o
);
    localparam logic [7:0] AMASK = 8'(MEM_BYTES - 1);

    eep_state_type q;
    eep_state_type n;
    logic [7:0] mem [256];
    logic [7:0] mem_rd;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic commit;

    assign mem_rd = mem[q.addr];
    assign rise = q.scl_s & ~q.scl_p;
    assign fall = ~q.scl_s & q.scl_p;
    assign start = q.scl_s & q.scl_p & ~q.sda_s & q.sda_p;
    assign stop = q.scl_s & q.scl_p & q.sda_s & ~q.sda_p;

    always_comb begin
        n = q;
        commit = 1'b0;
        n.scl_m = scl_i;
        n.scl_s = q.scl_m;
        n.scl_p = q.scl_s;
        n.sda_m = sda_i;
        n.sda_s = q.sda_m;
        n.sda_p = q.sda_s;
        n.wp_m = wp_i;
        n.wp_s = q.wp_m;
        n.sda_out = 1'b0;
        if (q.busy) begin
            if (q.tmr <= TMR_ONE) begin
                n.busy = 1'b0;
                n.mask = '0;
                commit = 1'b1;
            end else begin
                n.tmr = q.tmr - TMR_ONE;
            end
        end
        if (stop) begin
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
            if ((q.st == ST_WDAT || q.st == ST_WACK) && |q.mask && !q.busy) begin
                n.busy = 1'b1;
                n.tmr = 32'(PROG_CYCLES);
                n.blk = q.wp_s && ((MEM_BYTES <= SMALL_BYTES) || q.page[4]);
            end
        end else if (start) begin
            n.st = ST_DEV;
            n.cnt = '0;
            n.sda_oe = 1'b0;
        end else if (rise) begin
            if (q.st inside {ST_DEV, ST_WADR, ST_WDAT} && q.cnt < BYTE_END) begin
                n.sh = {q.sh[6:0], q.sda_s};
                n.cnt = q.cnt + 4'h1;
            end else if (q.st == ST_RDAT && q.cnt < BYTE_END) begin
                n.cnt = q.cnt + 4'h1;
            end else if (q.st == ST_RACK) begin
                n.mack = ~q.sda_s;
                if (q.sda_s) begin
                    n.st = ST_IGN;
                end
            end
        end else if (fall) begin
            unique case (q.st)
                ST_IDLE, ST_IGN: begin
                    n.sda_oe = 1'b0;
                end
                ST_DEV: begin
                    if (q.cnt == BYTE_END) begin
                        if (q.sh[7:4] == DEV_CODE && !q.busy) begin
                            n.sda_oe = 1'b1;
                            n.st = ST_DACK;
                        end else begin
                            n.st = ST_IGN;
                        end
                    end
                end
                ST_DACK: begin
                    n.cnt = '0;
                    if (q.sh[0]) begin
                        n.st = ST_RDAT;
                        n.sh = mem_rd;
                        n.sda_oe = ~mem_rd[7];
                    end else begin
                        n.st = ST_WADR;
                        n.sda_oe = 1'b0;
                    end
                end
                ST_WADR: begin
                    if (q.cnt == BYTE_END) begin
                        n.addr = q.sh & AMASK;
                        n.page = n.addr[7:3];
                        n.mask = '0;
                        n.sda_oe = 1'b1;
                        n.st = ST_AACK;
                    end
                end
                ST_AACK: begin
                    n.sda_oe = 1'b0;
                    n.cnt = '0;
                    n.st = ST_WDAT;
                end
                ST_WDAT: begin
                    if (q.cnt == BYTE_END) begin
                        n.pbuf[q.addr[2:0]] = q.sh;
                        n.mask[q.addr[2:0]] = 1'b1;
                        n.addr = {q.addr[7:3], q.addr[2:0] + 3'h1};
                        n.sda_oe = 1'b1;
                        n.st = ST_WACK;
                    end
                end
                ST_WACK: begin
                    n.sda_oe = 1'b0;
                    n.cnt = '0;
                    n.st = ST_WDAT;
                end
                ST_RDAT: begin
                    if (q.cnt == BYTE_END) begin
                        n.sda_oe = 1'b0;
                        n.addr = (q.addr + 8'h01) & AMASK;
                        n.mack = 1'b0;
                        n.st = ST_RACK;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.sda_oe = ~q.sh[6];
                    end
                end
                ST_RACK: begin
                    if (q.mack) begin
                        n.st = ST_RDAT;
                        n.cnt = '0;
                        n.sh = mem_rd;
                        n.sda_oe = ~mem_rd[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= RST_STATE;
        end else begin
            q <= n;
        end
    end

    // Programming commits the marked bytes of the buffered page once the write time has elapsed, unless protect blocks the page.
    always_ff @(posedge mclk_i) begin
        if (commit && !q.blk) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (q.mask[i]) begin
                    mem[{q.page, 3'(i)}] <= q.pbuf[i];
                end
            end
        end
    end

    assign sda_o = q.sda_out;
    assign sda_oe_o = q.sda_oe;
    assign busy_o = q.busy;

    default clocking dcb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_STOP_IDLE: assert property (stop |=> q.st == ST_IDLE && !q.sda_oe)
        else $error("stop did not return to idle");

    AST_START_DEV: assert property (start |=> q.st == ST_DEV && q.cnt == 4'h0)
        else $error("start did not open address phase");

    AST_BUSY_NOACK: assert property (
        fall && q.st == ST_DEV && q.cnt == BYTE_END && q.busy
        |=> q.st == ST_IGN && !q.sda_oe)
        else $error("address acknowledged while programming");

    AST_MATCH_ACK: assert property (
        fall && q.st == ST_DEV && q.cnt == BYTE_END && !q.busy && q.sh[7:4] == DEV_CODE
        |=> q.st == ST_DACK && q.sda_oe)
        else $error("matching idle address not acknowledged");

    AST_MISMATCH: assert property (
        fall && q.st == ST_DEV && q.cnt == BYTE_END && q.sh[7:4] != DEV_CODE
        |=> q.st == ST_IGN)
        else $error("foreign device code not ignored");

    AST_READ_SEL: assert property (
        fall && q.st == ST_DACK && q.sh[0] |=> q.st == ST_RDAT)
        else $error("read bit did not start read");

    AST_WRITE_ACK: assert property (
        fall && q.st == ST_WDAT && q.cnt == BYTE_END
        |=> q.sda_oe && q.st == ST_WACK)
        else $error("write byte not acknowledged");

    AST_PAGE_FIXED: assert property (
        fall && q.st == ST_WDAT && q.cnt == BYTE_END
        |=> q.addr[7:3] == $past(q.addr[7:3]) && q.addr[2:0] == $past(q.addr[2:0]) + 3'h1)
        else $error("page address bits moved");

    AST_READ_INC: assert property (
        fall && q.st == ST_RDAT && q.cnt == BYTE_END
        |=> q.addr == (($past(q.addr) + 8'h01) & AMASK) && !q.sda_oe)
        else $error("read address not advanced");

    AST_LAUNCH: assert property (
        stop && (q.st == ST_WDAT || q.st == ST_WACK) && |q.mask && !q.busy
        |=> q.busy [*8])
        else $error("programming not launched after write");

    AST_HOLD: assert property (q.busy && q.tmr > TMR_ONE |=> q.busy)
        else $error("programming aborted early");

    AST_NACK_REL: assert property (q.st == ST_IGN |-> !q.sda_oe)
        else $error("data driven after missing acknowledge");

    AST_DRIVE_LOW: assert property ($rose(q.sda_oe) |-> !q.scl_s)
        else $error("data changed with clock high");

    COV_BYTE_WRITE: cover property (stop && q.st == ST_WDAT && |q.mask && !q.busy ##1 q.busy);
    COV_SEQ_READ: cover property (fall && q.st == ST_RACK && q.mack);
    COV_POLL_NACK: cover property (fall && q.st == ST_DEV && q.cnt == BYTE_END && q.busy);
    COV_PAGE_WRAP: cover property (fall && q.st == ST_WDAT && q.cnt == BYTE_END
        && q.addr[2:0] == 3'h7);
endmodule // eep_slave

// ===== test/eep_master.sv
`timescale 1ns/100ps
module eep_master (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // The clock line idles high and the data line is released between frames.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Start comes only at frame begin or after a byte.
    task automatic start();
        sda_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
        tick(4);
    endtask

    // Stop releases the data line while the clock line is high.
    task automatic stop();
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask

    // Data changes only while the clock line is low.
    task automatic clk(input logic b, output logic r);
        sda_o <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(6);
        r = sda_i;
        tick(2);
        scl_o <= 1'b0;
        tick(4);
    endtask

    // Eight bits out, then the line is released for the ack slot.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk(d[i], r);
        end
        clk(1'b1, ack);
    endtask

    // Eight bits in, then ack low or a released line to end.
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk(1'b1, d[i]);
        end
        clk(nack, r);
    endtask
endmodule // eep_master

// ===== test/eep_slave_test.sv
`timescale 1ns/100ps
module eep_slave_test;
    logic mclk_i, nrst_i, wp_i, scl, m_sda, sda_o, sda_oe_o, busy_o, ack;
    wire sda_w;
    int fail_count = 0;
    int checks = 0;

    // Open-drain wire with pull-up.
    assign sda_w = m_sda & ~sda_oe_o;

    eep_slave #(.MEM_BYTES(256), .PROG_CYCLES(400)) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .scl_i(scl), .sda_i(sda_w), .wp_i(wp_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .busy_o(busy_o));
    eep_master mst_u (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy_o !== lvl && n < lim) begin
            @(posedge mclk_i);
            n++;
        end
        chk_bit(busy_o, lvl);
        if (busy_o !== lvl) give_verdict();
    endtask

    // Writes n bytes counting up from d0 at word address a.
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input int n, input logic wt);
        mst_u.start();
        mst_u.wbyte(8'ha6, ack);
        chk_bit(ack, 1'b0); // Select bits ignored.
        mst_u.wbyte(a, ack);
        chk_bit(ack, 1'b0); // Word address acked.
        for (int i = 0; i < n; i++) begin
            mst_u.wbyte(d0 + 8'(i), ack);
            chk_bit(ack, 1'b0); // Data acked.
        end
        mst_u.stop();
        wait_busy(1'b1, 8); // Stop launches programming.
        if (wt) wait_busy(1'b0, 450); // Programming ends.
    endtask

    // Reads n bytes from a or from the counter, expecting e0 upward.
    task automatic rd(input logic rnd, input logic [7:0] a, input logic [7:0] e0, input int n);
        logic [7:0] d;
        if (rnd) begin
            mst_u.start();
            mst_u.wbyte(8'ha0, ack);
            mst_u.wbyte(a, ack);
            chk_bit(ack, 1'b0); // Dummy write acked.
        end
        mst_u.start();
        mst_u.wbyte(8'ha1, ack);
        chk_bit(ack, 1'b0); // Read address acked.
        for (int i = 0; i < n; i++) begin
            mst_u.rbyte(i == n - 1, d);
            chk_byte(d, e0 + 8'(i)); // Sequential data.
        end
        chk_bit(sda_oe_o, 1'b0); // Line released after nack.
        mst_u.stop();
        chk_bit(busy_o, 1'b0); // No programming after a read.
    endtask

    task automatic t_poll();
        wr(8'h10, 8'h5a, 1, 1'b0);
        for (int i = 0; i < 2; i++) begin
            mst_u.start();
            mst_u.wbyte(8'ha0 | 8'(i), ack);
            chk_bit(ack, 1'b1); // No ack while busy.
            mst_u.stop();
        end
        wait_busy(1'b0, 450); // Programming ends.
        mst_u.start();
        mst_u.wbyte(8'ha0, ack);
        chk_bit(ack, 1'b0); // Ack once done.
        mst_u.wbyte(8'h11, ack);
        chk_bit(ack, 1'b0); // Word address follows the poll.
        mst_u.wbyte(8'h5b, ack);
        chk_bit(ack, 1'b0); // Data follows the poll.
        mst_u.stop();
        wait_busy(1'b1, 8); // Stop launches programming.
        wait_busy(1'b0, 450); // Programming ends.
        rd(1'b1, 8'h10, 8'h5a, 2); // Both bytes stored.
    endtask

    task automatic t_page();
        wr(8'h1e, 8'hd0, 10, 1'b1); // Ten bytes into one page.
        rd(1'b0, 8'h00, 8'hd2, 1); // Counter wraps to page start.
        rd(1'b1, 8'h18, 8'hd2, 8); // Last eight bytes win.
        wr(8'hff, 8'he0, 1, 1'b1); // Last location.
        wr(8'h00, 8'he1, 1, 1'b1); // First location.
        rd(1'b1, 8'hff, 8'he0, 2); // Read wraps to zero.
    endtask

    task automatic t_ignore();
        mst_u.start();
        mst_u.wbyte(8'h26, ack);
        chk_bit(ack, 1'b1); // Wrong code refused.
        mst_u.wbyte(8'h10, ack);
        chk_bit(ack, 1'b1); // Rest ignored.
        mst_u.stop();
        chk_bit(busy_o, 1'b0); // Nothing programmed.
    endtask

    task automatic t_protect();
        wr(8'h90, 8'h33, 1, 1'b1); // Unprotected write.
        wp_i <= 1'b1;
        wr(8'h90, 8'h44, 1, 1'b1); // Protected upper half.
        wr(8'h20, 8'h77, 1, 1'b1); // Open lower half.
        rd(1'b1, 8'h90, 8'h33, 1); // Upper half blocked.
        rd(1'b1, 8'h20, 8'h77, 1); // Lower half written.
        wp_i <= 1'b0;
        wr(8'h91, 8'h55, 1, 1'b0); // Launch without waiting.
        wp_i <= 1'b1;
        wait_busy(1'b0, 450); // Programming ends.
        rd(1'b1, 8'h91, 8'h55, 1); // Cycle not aborted.
        wp_i <= 1'b0;
    endtask

    // A reset in mid-run clears the address counter but keeps the array.
    task automatic t_reset();
        nrst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk_bit(sda_oe_o, 1'b0); // Line released.
        chk_bit(busy_o, 1'b0); // Idle.
        rd(1'b0, 8'h00, 8'he1, 1); // Counter back at zero.
    endtask

    initial begin
        nrst_i = 1'b0;
        wp_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk_bit(sda_oe_o, 1'b0); // Line released.
        chk_bit(sda_o, 1'b0); // Drive value low.
        chk_bit(busy_o, 1'b0); // Idle.
        t_poll();
        t_page();
        t_ignore();
        t_protect();
        t_reset();
        give_verdict();
    end
endmodule // eep_slave_test
